/* File: hw/pbw_pkg.sv */
// Purpose: shared constants for the push-button wiper counter
// Assumes: 40 MHz clock, all intervals counted in 1 ms ticks
// Notes:   time figures are kept in ms, tick counts derive from them
package pbw_pkg;

  // ---------------------------------------------------------------
  // clock and tick
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

  // ---------------------------------------------------------------
  // intervals in ms
  // ---------------------------------------------------------------
  localparam int DEBOUNCE_MS   = 15;   // debounce_window
  localparam int SPACING_MS    = 2;    // event_spacing
  localparam int SLOW_MS       = 250;
  localparam int FAST_MS       = 50;
  localparam int SLOW_SPAN_MS  = 1000;
  localparam int IDLE_SAVE_MS  = 2000;
  localparam int SHDN_MS       = 2000; // shutdown_hold_time
  localparam int RESUME_MS     = 250;
  localparam int NV_WRITE_MS   = 10;

  // ---------------------------------------------------------------
  // the same intervals in ticks
  // ---------------------------------------------------------------
  localparam int TMR_W = 11;
  localparam logic [TMR_W-1:0] DEBOUNCE_TK  = TMR_W'(DEBOUNCE_MS / TICK_MS);
  localparam logic [TMR_W-1:0] RELEASE_TK   = TMR_W'(SPACING_MS / TICK_MS);
  localparam logic [TMR_W-1:0] SLOW_TK      = TMR_W'(SLOW_MS / TICK_MS);
  localparam logic [TMR_W-1:0] FAST_TK      = TMR_W'(FAST_MS / TICK_MS);
  localparam logic [TMR_W-1:0] SLOW_SPAN_TK = TMR_W'(SLOW_SPAN_MS / TICK_MS);
  localparam logic [TMR_W-1:0] IDLE_SAVE_TK = TMR_W'(IDLE_SAVE_MS / TICK_MS);
  localparam logic [TMR_W-1:0] SHDN_TK      = TMR_W'(SHDN_MS / TICK_MS);
  localparam logic [TMR_W-1:0] RESUME_TK    = TMR_W'(RESUME_MS / TICK_MS);
  localparam logic [TMR_W-1:0] NV_WRITE_TK  = TMR_W'(NV_WRITE_MS / TICK_MS);
  localparam logic [TMR_W-1:0] TMR_MAX      = 11'h7ff;

  // ---------------------------------------------------------------
  // wiper
  // ---------------------------------------------------------------
  localparam int POS_W = 4;
  localparam int TAPS  = 16;
  localparam logic [POS_W-1:0] POS_TOP = 4'hf;
  localparam logic [POS_W-1:0] POS_BOT = 4'h0;
  localparam logic [TAPS-1:0]  TAP_LOW = 16'h0001;

  typedef enum logic [3:0] {
    ST_INIT, ST_IDLE, ST_SINGLE, ST_MULTI, ST_IGNORE, ST_SHDN_REL,
    ST_SHDN, ST_RESUME, ST_LOCK, ST_STORE
  } pbw_state_t;

endpackage

/* File: hw/pbw_debounce.sv */
// Purpose: synchronise and debounce one active-low button pin
// Assumes: tick is a one-cycle pulse every ms
// Notes:   press needs a steady low, release a shorter steady high
`timescale 1ns/1ps
module pbw_debounce
  import pbw_pkg::*;
(
  input  wire logic clk,      // system clock
  input  wire logic sys_rst,  // async reset, high
  input  wire logic tick,     // ms enable
  input  wire logic pin_n,    // raw button, low = pressed
  output logic      level_n,  // synchronised pin level
  output logic      pressed   // debounced press
);

  logic             sync1_q;
  logic             sync2_q;
  logic [TMR_W-1:0] cnt_q;
  logic             pressed_q;
  logic             differs;

  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_n;
      sync2_q <= sync1_q;
    end
  end

  // the pin disagrees with the debounced state
  assign differs = (sync2_q == pressed_q);

  // ---------------------------------------------------------------
  // stability counter
  // ---------------------------------------------------------------
  // short glitches reset count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q     <= '0;
      pressed_q <= 1'b0;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (tick) begin
      if (cnt_q == (pressed_q ? RELEASE_TK : DEBOUNCE_TK) - 11'h001) begin
        cnt_q     <= '0;
        pressed_q <= !pressed_q;
      end else begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  assign level_n = sync2_q;
  assign pressed = pressed_q;

  AST_DEB_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pressed_q) |-> $past(cnt_q) == DEBOUNCE_TK - 11'h001)
    else $error("press accepted before debounce time");

endmodule

/* File: hw/pbw_tap_decode.sv */
// Purpose: one-hot tap select from the wiper counter
// Assumes: force_low selects the tap next to the low terminal
// Notes:   output is registered
`timescale 1ns/1ps
module pbw_tap_decode
  import pbw_pkg::*;
(
  input  wire logic             clk,       // system clock
  input  wire logic             sys_rst,   // async reset, high
  input  wire logic [POS_W-1:0] pos,       // wiper counter
  input  wire logic             force_low, // shutdown override
  output logic      [TAPS-1:0]  tap_sel    // one-hot tap switches
);

  logic [TAPS-1:0] sel_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // one switch per tap
  for (genvar i = 0; i < TAPS; i++) begin : g_tap
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        sel_q[i] <= TAP_LOW[i];
      end else begin
        sel_q[i] <= force_low ? TAP_LOW[i] : (pos == POS_W'(i));
      end
    end
  end

  assign tap_sel = sel_q;

  AST_ONEHOT: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot(sel_q))
    else $error("tap select not one-hot");

endmodule

/* File: hw/pbw_wiper_ctrl.sv */
// Purpose: push-button control of a 16-tap wiper with store and shutdown
// Assumes: inputs synchronous-ish buttons with pull-ups, 40 MHz clock
// Notes:   nonvolatile cell is outside; recall value is read after reset
`timescale 1ns/1ps
module pbw_wiper_ctrl
  import pbw_pkg::*;
#(
  parameter int TICK_CLKS = TICK_CYCLES  // clocks per ms tick
)(
  input  wire logic             clk,               // 40 MHz clock
  input  wire logic             sys_rst,           // async reset, high
  input  wire logic             step_up_button_n,  // up button, low
  input  wire logic             step_down_button_n,// down button, low
  input  wire logic             store_mode_select_n,// store pin, low
  input  wire logic [POS_W-1:0] nv_recall_value,   // saved wiper value
  output logic      [TAPS-1:0]  tap_sel,           // one-hot tap switches
  output logic                  chain_top_en,      // high_terminal link
  output logic      [POS_W-1:0] wiper_pos,         // wiper counter
  output logic                  nv_store_stb,      // write request pulse
  output logic      [POS_W-1:0] nv_store_data,     // value to write
  output logic                  store_busy,        // write in progress
  output logic                  shutdown_active,   // in shutdown
  output logic                  auto_store_mode    // auto save selected
);

  pbw_state_t       st_q;
  pbw_state_t       st_d;
  logic [15:0]      div_q;
  logic             tick;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] rep_q;
  logic [TMR_W-1:0] period;
  logic [POS_W-1:0] pos_q;
  logic             dir_up_q;
  logic             dirty_q;
  logic             auto_q;
  logic             shdn_q;
  logic             stb_q;
  logic [POS_W-1:0] data_q;
  logic             up;
  logic             dn;
  logic             sp;
  logic             sp_level_n;
  logic             step_up;
  logic             step_dn;
  logic             store_go;
  logic             load;
  logic             rep_due;

  // ---------------------------------------------------------------
  // ms prescaler
  // ---------------------------------------------------------------
  // one tick per ms
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
    end else if (div_q == 16'(TICK_CLKS - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign tick = (div_q == 16'(TICK_CLKS - 1));

  // ---------------------------------------------------------------
  // button front ends
  // ---------------------------------------------------------------
  // synchronised debouncers
  pbw_debounce u_db_up (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick),
    .pin_n   (step_up_button_n),
    .level_n (),
    .pressed (up)
  );
  pbw_debounce u_db_dn (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick),
    .pin_n   (step_down_button_n),
    .level_n (),
    .pressed (dn)
  );
  pbw_debounce u_db_sp (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick),
    .pin_n   (store_mode_select_n),
    .level_n (sp_level_n),
    .pressed (sp)
  );

  // ---------------------------------------------------------------
  // control state machine
  // ---------------------------------------------------------------
  // slow for first second
  assign period  = (tmr_q >= SLOW_SPAN_TK) ? FAST_TK : SLOW_TK;
  assign rep_due = tick && (rep_q == period - 11'h001);

  always_comb begin
    st_d     = st_q;
    step_up  = 1'b0;
    step_dn  = 1'b0;
    store_go = 1'b0;
    load     = 1'b0;
    case (st_q)
      ST_INIT: begin
        if (tick) begin
          load = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!auto_q && sp) begin
          st_d = ST_LOCK;
        end else if (up && dn) begin
          st_d = ST_MULTI;
        end else if (up) begin
          step_up = 1'b1;
          st_d    = ST_SINGLE;
        end else if (dn) begin
          step_dn = 1'b1;
          st_d    = ST_SINGLE;
        end else if (auto_q && dirty_q && tmr_q >= IDLE_SAVE_TK) begin
          store_go = 1'b1;
          st_d     = ST_STORE;
        end
      end
      ST_SINGLE: begin
        if (!auto_q && sp) begin
          st_d = ST_IGNORE;
        end else if (up && dn) begin
          st_d = (tmr_q < DEBOUNCE_TK) ? ST_MULTI : ST_IGNORE;
        end else if (!up && !dn) begin
          st_d = ST_IDLE;
        end else if (rep_due) begin
          step_up = dir_up_q;
          step_dn = !dir_up_q;
        end
      end
      ST_MULTI: begin
        if (!(up && dn)) begin
          st_d = ST_IGNORE;
        end else if (tmr_q >= SHDN_TK) begin
          st_d = ST_SHDN_REL;
        end
      end
      ST_IGNORE: begin
        if (!up && !dn && !(sp && !auto_q)) begin
          st_d = ST_IDLE;
        end
      end
      ST_SHDN_REL: begin
        if (!up && !dn && !(sp && !auto_q)) begin
          st_d = ST_SHDN;
        end
      end
      ST_SHDN: begin
        if (up || dn || (sp && !auto_q)) begin
          st_d = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (!up && !dn && !(sp && !auto_q)) begin
          st_d = ST_IDLE;
        end else if ((up ^ dn) && tmr_q >= RESUME_TK) begin
          step_up = up;
          step_dn = dn;
          st_d    = ST_SINGLE;
        end
      end
      ST_LOCK: begin
        if (!sp) begin
          store_go = 1'b1;
          st_d     = ST_STORE;
        end
      end
      ST_STORE: begin
        if (tmr_q >= NV_WRITE_TK) begin
          st_d = ST_IGNORE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_INIT;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  // time spent in state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_q <= '0;
    end else if (st_d != st_q) begin
      tmr_q <= '0;
    end else if (tick && tmr_q != TMR_MAX) begin
      tmr_q <= tmr_q + 11'h001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rep_q <= '0;
    end else if (st_d != st_q || step_up || step_dn) begin
      rep_q <= '0;
    end else if (tick) begin
      rep_q <= rep_q + 11'h001;
    end
  end

  // ---------------------------------------------------------------
  // wiper counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_q <= POS_BOT;
    end else if (load) begin
      pos_q <= nv_recall_value;
    end else if (step_up && pos_q != POS_TOP) begin
      pos_q <= pos_q + 4'h1;
    end else if (step_dn && pos_q != POS_BOT) begin
      pos_q <= pos_q - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_up_q <= 1'b1;
    end else if (step_up) begin
      dir_up_q <= 1'b1;
    end else if (step_dn) begin
      dir_up_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dirty_q <= 1'b0;
    end else if (step_up || step_dn) begin
      dirty_q <= 1'b1;
    end else if (store_go) begin
      dirty_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // store mode and store request
  // ---------------------------------------------------------------
  // strap caught after reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_q <= 1'b0;
    end else if (load) begin
      auto_q <= !sp_level_n;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stb_q  <= 1'b0;
      data_q <= '0;
    end else begin
      stb_q <= store_go;
      if (store_go) begin
        data_q <= pos_q;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shdn_q <= 1'b0;
    end else begin
      shdn_q <= (st_d == ST_SHDN_REL) || (st_d == ST_SHDN);
    end
  end

  pbw_tap_decode u_dec (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pos       (pos_q),
    .force_low (shdn_q),
    .tap_sel   (tap_sel)
  );

  assign chain_top_en    = !shdn_q;
  assign wiper_pos       = pos_q;
  assign nv_store_stb    = stb_q;
  assign nv_store_data   = data_q;
  assign store_busy      = (st_q == ST_STORE);
  assign shutdown_active = shdn_q;
  assign auto_store_mode = auto_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_STEP_ONE: assert property (
    $past(st_q) != ST_INIT && pos_q != $past(pos_q) |->
      pos_q == $past(pos_q) + 4'h1 || pos_q == $past(pos_q) - 4'h1)
    else $error("wiper moved by more than one tap");
  AST_SAT_TOP: assert property (
    pos_q == POS_TOP && step_up |=> pos_q == POS_TOP)
    else $error("counter wrapped at top");
  AST_SAT_BOT: assert property (
    pos_q == POS_BOT && step_dn |=> pos_q == POS_BOT)
    else $error("counter wrapped at bottom");
  AST_SHDN_TAP: assert property (
    shdn_q && $past(shdn_q) |-> !chain_top_en && tap_sel == TAP_LOW)
    else $error("shutdown output wrong");
  AST_LOCK_NOSTEP: assert property (
    st_q == ST_LOCK |-> !step_up && !step_dn)
    else $error("step taken while store pin low");
  AST_WRITE_IGNORE: assert property (
    st_q == ST_STORE |-> !step_up && !step_dn && !store_go)
    else $error("input acted on during write");
  AST_AUTO_IDLE: assert property (
    store_go && auto_q |-> tmr_q >= IDLE_SAVE_TK && st_q == ST_IDLE)
    else $error("auto save before idle time");
  AST_SLOW_RATE: assert property (
    st_q == ST_SINGLE && (step_up || step_dn) && tmr_q < SLOW_SPAN_TK
      |-> rep_q == SLOW_TK - 11'h001)
    else $error("slow repeat spacing wrong");
  AST_FAST_RATE: assert property (
    st_q == ST_SINGLE && (step_up || step_dn) && tmr_q >= SLOW_SPAN_TK
      |-> rep_q == FAST_TK - 11'h001)
    else $error("fast repeat spacing wrong");
  AST_RELEASE_IDLE: assert property (
    st_q == ST_SINGLE && !up && !dn && !(sp && !auto_q)
      |=> st_q == ST_IDLE ##1 !step_up && !step_dn)
    else $error("release did not stop stepping");
  AST_STORE_DATA: assert property (
    store_go |=> nv_store_stb && nv_store_data == $past(pos_q))
    else $error("store pulse or data wrong");
  AST_SHDN_KEEP: assert property (
    st_q == ST_SHDN |-> $stable(pos_q))
    else $error("wiper value lost in shutdown");

  CVR_REPEAT_FAST: cover property (
    st_q == ST_SINGLE && step_up && tmr_q >= SLOW_SPAN_TK);
  CVR_SHUTDOWN:    cover property (st_q == ST_SHDN ##1 st_q == ST_RESUME);
  CVR_AUTO_SAVE:   cover property (store_go && auto_q);
  CVR_MANUAL_SAVE: cover property (st_q == ST_LOCK ##1 st_q == ST_STORE);

endmodule

/* File: tb/pbw_button_model.sv */
// Purpose: push button with contact chatter for the wiper bench
// Assumes: pin has a pull-up, button shorts it to ground
// Notes:   chatter lasts a few clocks, far below the debounce window
`timescale 1ns/1ps
module pbw_button_model (
  input  wire logic clk,   // system clock
  input  wire logic press, // finger on button
  output logic      pin_n  // button pin, low when closed
);
  logic [3:0] bounce_q = 4'h0;
  logic       press_q  = 1'b0;

  always_ff @(posedge clk) begin
    press_q <= press;
    if (press && !press_q) begin
      bounce_q <= 4'h8;
    end else if (bounce_q != 4'h0) begin
      bounce_q <= bounce_q - 4'h1;
    end
  end

  // open contact returns to the pull-up level
  assign pin_n = (bounce_q != 4'h0) ? bounce_q[0] : !press;
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench for pbw_wiper_ctrl
// Assumes: 4 clocks per ms tick, buttons from pbw_button_model
// Notes:   wiper and store results queued, a watcher compares them
`timescale 1ns/1ps
module testbench;
  import pbw_pkg::*;
  localparam int MS = 4;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [2:0]       prs = 3'h0;
  logic [POS_W-1:0] recall = 4'h0;
  wire  [2:0]       pin_n;
  logic [TAPS-1:0]  tap_sel;
  logic             top_en, stb, busy, shdn, auto_m;
  logic [POS_W-1:0] pos, sdata, exp_pos, last;
  logic [1:0]       sd_h = 2'h0;
  logic [POS_W-1:0] pos_q[$];
  logic [POS_W-1:0] st_q[$];
  int               failures = 0;
  int               comparisons = 0;
  int               cyc = 0;
  int               seed = 32'h5ecd;
  int               g;

  for (genvar b = 0; b < 3; b++) begin : btn_g
    pbw_button_model pbw_button_model_i (.clk(clk), .press(prs[b]),
      .pin_n(pin_n[b]));
  end

  pbw_wiper_ctrl #(.TICK_CLKS(MS)) pbw_wiper_ctrl_i (.clk(clk),
    .sys_rst(sys_rst), .step_up_button_n(pin_n[0]),
    .step_down_button_n(pin_n[1]), .store_mode_select_n(pin_n[2]),
    .nv_recall_value(recall), .tap_sel(tap_sel), .chain_top_en(top_en),
    .wiper_pos(pos), .nv_store_stb(stb), .nv_store_data(sdata),
    .store_busy(busy), .shutdown_active(shdn), .auto_store_mode(auto_m));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic bit ok(bit c);
    comparisons++;
    return c;
  endfunction

  task automatic fail(string m);
    failures++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic ms(int n);
    repeat (n * MS) @(posedge clk);
  endtask

  task automatic exp_step(bit up);
    if (up && exp_pos != POS_TOP) begin
      exp_pos++;
      pos_q.push_back(exp_pos);
    end else if (!up && exp_pos != POS_BOT) begin
      exp_pos--;
      pos_q.push_back(exp_pos);
    end
  endtask

  task automatic btn(int b, int hold);
    @(posedge clk) prs[b] <= 1'b1;
    ms(hold);
    prs[b] <= 1'b0;
    ms(5);
  endtask

  task automatic done_test(string name);
    @(negedge clk);
    if (!ok(pos === exp_pos && pos_q.size() == 0)) fail("wiper count");
    $display("test %s done", name);
  endtask

  task automatic boot(bit auto);
    logic [POS_W-1:0] r;
    r = 4'($random(seed));
    @(posedge clk);
    sys_rst <= 1'b1;
    prs <= {auto, 2'b00};
    recall <= r;
    repeat (16) @(posedge clk);
    exp_pos = r;
    pos_q.delete();
    if (r != POS_BOT) pos_q.push_back(r);
    sys_rst <= 1'b0;
    ms(3);
    @(negedge clk);
    if (!ok(auto_m === auto && pos === r)) fail("power-up state");
  endtask

  task automatic ramp(int b);
    int n;
    int k;
    int gap;
    logic [POS_W-1:0] p;
    n = (b == 0) ? 15 - exp_pos : exp_pos;
    for (k = 0; k < n; k++) exp_step(b == 0);
    @(posedge clk) prs[b] <= 1'b1;
    for (k = 0; k < n; k++) begin
      p = pos;
      gap = 0;
      while (pos === p && gap < 400 * MS) begin
        @(negedge clk);
        gap++;
      end
      if (k > 0 && k < 4) begin
        if (!ok(gap >= 100*MS && gap <= 390*MS)) fail("slow");
      end
      if (k > 4 && !ok(gap >= 25*MS && gap <= 78*MS)) fail("fast");
    end
    ms(200);
    prs[b] <= 1'b0;
    ms(5);
  endtask

  // ---------------------------------------------------------------
  // watcher and timeout
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (!sys_rst && pos !== last) begin
      if (!ok(pos_q.size() > 0 && pos === pos_q[0])) fail("wiper step");
      if (pos_q.size() > 0) void'(pos_q.pop_front());
    end
    if (!sys_rst && stb === 1'b1) begin
      if (!ok(st_q.size() > 0 && sdata === st_q[0])) fail("store data");
      if (st_q.size() > 0) void'(st_q.pop_front());
    end
    if (!sys_rst && shdn === 1'b0 && sd_h == 2'h0) begin
      if (!ok(tap_sel === (16'h0001 << last))) fail("tap select");
    end
    sd_h = {sd_h[0], shdn === 1'b1};
    last = pos;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail("timeout");
      results();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    boot(1'b0);
    for (int i = 0; i < 4; i++) begin
      btn(i % 2, 1 + ($unsigned($random(seed)) % 12));
    end
    done_test("short presses");
    exp_step(1'b1);
    btn(0, 20);
    exp_step(1'b0);
    btn(1, 20);
    done_test("single steps");
    ramp(0);
    ramp(1);
    done_test("repeat and saturate");
    st_q.push_back(exp_pos);
    @(posedge clk) prs[2] <= 1'b1;
    ms(20);
    btn(0, 30);
    // down held across the store so its press lands inside the write
    prs[1] <= 1'b1;
    ms(10);
    prs[2] <= 1'b0;
    g = 0;
    while (stb !== 1'b1 && g < 20 * MS) begin
      @(negedge clk);
      g++;
    end
    if (!ok(stb === 1'b1 && busy === 1'b1)) fail("manual store");
    ms(15);
    prs[1] <= 1'b0;
    ms(5);
    done_test("manual store");
    exp_step(1'b1);
    @(posedge clk) prs[0] <= 1'b1;
    ms(5);
    prs[1] <= 1'b1;
    ms(2100);
    @(negedge clk);
    if (!ok(shdn === 1'b1 && top_en === 1'b0 &&
        tap_sel === TAP_LOW)) fail("sd");
    @(posedge clk) prs <= 3'h0;
    ms(5);
    exp_step(1'b1);
    btn(0, 400);
    if (!ok(shdn === 1'b0 && top_en === 1'b1)) fail("shutdown exit");
    done_test("shutdown");
    exp_step(1'b1);
    @(posedge clk) prs[0] <= 1'b1;
    ms(40);
    prs[1] <= 1'b1;
    ms(2100);
    if (!ok(shdn === 1'b0)) fail("late second press");
    prs <= 3'h0;
    ms(5);
    done_test("late both");
    boot(1'b1);
    g = (exp_pos != POS_TOP) ? 0 : 1;
    exp_step(g == 0);
    st_q.push_back(exp_pos);
    btn(g, 20);
    g = 0;
    while (stb !== 1'b1 && g < 2200 * MS) begin
      @(negedge clk);
      g++;
    end
    if (!ok(g >= 1900 * MS && g <= 2100 * MS)) fail("idle store time");
    done_test("auto store");
    results();
  end
endmodule
